// ===== logic/pmu_settings_pkg.sv
package pmu_settings_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int NUM_BUCKS = 5;
  localparam int NUM_SETTINGS = 15;
  localparam int NVM_BYTES = 16;
  localparam int CLK_MHZ = 20;
  localparam int VOLT_W = 13;
  localparam int DLY_W = 20;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEQ = 8'h0C;
  localparam logic [7:0] ADDR_SUPPLY = 8'h0D;
  localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_SETTING_CONTROL = 8'h0F;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Index 0 is regulator one, index 4 is regulator five.
  localparam logic [4:0][3:0] VL_ADDR = {4'h5, 4'h4, 4'h2, 4'h3, 4'h1};
  localparam logic [4:0][3:0] CFG_ADDR = {4'hB, 4'hA, 4'h8, 4'h9, 4'h7};
  localparam logic [4:0][2:0] OFF_BIT = {3'h5, 3'h4, 3'h2, 3'h3, 3'h1};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VL_SEL_BIT = 7;
  localparam int VL_OC_BIT = 6;
  localparam int CFG_PFM_BIT = 7;
  localparam int CFG_ORDER_LSB = 4;
  localparam int CFG_SLEW_LSB = 2;
  localparam int CFG_LS_BIT = 1;
  localparam int CFG_UVM_BIT = 0;
  localparam int SEQ_FIX_BIT = 7;
  localparam int SEQ_STEP_LSB = 5;
  localparam int SEQ_PLACE_LSB = 3;
  localparam int SUP_EXTERNAL_SUPPLY_MASK_BIT = 4;
  localparam int SUP_INTERNAL_SUPPLY_MASK_BIT = 3;
  localparam int SUP_MONITOR_DEGLITCH_LSB = 1;
  localparam int CTRL_DSM_BIT = 7;
  localparam int CTRL_PD_BIT = 6;
  localparam int CTRL_LDO_BIT = 0;
  localparam int SET_BUSY_BIT = 3;
  localparam int SET_SDI_BIT = 2;

  // ----------------------------------------------------------------
  // Reset and factory image, index 0 is offset 0x00
  // ----------------------------------------------------------------
  localparam logic [NUM_SETTINGS-1:0][7:0] FACTORY_IMAGE = {
    8'h40, 8'h00, 8'hA8, 8'h10, 8'h0C, 8'h30, 8'h00, 8'h20,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CHECK_SEED = 8'hA5;

  // ----------------------------------------------------------------
  // Voltages in half-millivolt units; class 0, 1, 2 = regulator 1, 2, 3-5
  // ----------------------------------------------------------------
  localparam logic [2:0][VOLT_W-1:0] VOLT_BASE = {13'h0578, 13'h0BB8, 13'h0708};
  localparam logic [2:0][VOLT_W-1:0] VOLT_STEP = {13'h0032, 13'h004B, 13'h0032};
  localparam logic [2:0][4:0] VOLT_CEIL = {5'h18, 5'h10, 5'h1C};
  localparam logic [2:0][3:0][VOLT_W-1:0] STRAP_VOLT = {
    {13'h0898, 13'h07D0, 13'h07D0, 13'h0898},
    {13'h0E10, 13'h0E10, 13'h0E10, 13'h0E10},
    {13'h0A8C, 13'h0A8C, 13'h0BB8, 13'h0960}};
  localparam logic [10:0] SLEW_STEP = 11'h1F4;

  // ----------------------------------------------------------------
  // Times
  // ----------------------------------------------------------------
  localparam int STEP_UNIT_US = 500;
  localparam int MAIN_BASE_MS = 10;
  localparam int MAIN_STEP_MS = 2;
  localparam int MAIN_FIXED_MS = 8;
  localparam logic [3:0][2:0] MONITOR_DEGLITCH_US = {3'h5, 3'h2, 3'h1, 3'h0};
  localparam int MONITOR_DEGLITCH_MAX_CYC = 5 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_NONE, CMD_SAVE, CMD_RESTORE, CMD_FACTORY} store_cmd_t;

  typedef struct packed {
    logic [VOLT_W-1:0] volt_half_mv;
    logic oc_enable;
    logic force_pwm;
    logic [2:0] order;
    logic [10:0] slew_v_per_us;
    logic low_side_off;
    logic uv_fault_en;
    logic off;
  } buck_ctrl_t;

endpackage

// ===== logic/nvm_store_engine.sv
module nvm_store_engine #(
  parameter int PROG_CYCLES = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Command
  input wire logic i_start,
  input wire pmu_settings_pkg::store_cmd_t i_cmd,
  input wire logic [pmu_settings_pkg::NUM_SETTINGS-1:0][7:0] i_image,
  // Results
  output logic o_busy,
  output logic o_done,
  output logic o_load,
  output logic [pmu_settings_pkg::NUM_SETTINGS-1:0][7:0] o_load_image,
  output logic o_integrity_fault
);
  import pmu_settings_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_READ, ST_CHECK, ST_FACTORY} eng_state_t;

  function automatic logic [7:0] checksum(input logic [NUM_SETTINGS-1:0][7:0] img);
    logic [7:0] acc;
    acc = CHECK_SEED;
    for (int i = 0; i < NUM_SETTINGS; i++) begin
      acc = {acc[6:0], acc[7]} ^ img[i];
    end
    return acc;
  endfunction

  // Worked out once at elaboration so that the reset branch loads only a constant.
  localparam logic [7:0] FACTORY_CHECK = checksum(FACTORY_IMAGE);

  eng_state_t state_q;
  store_cmd_t cmd_q;
  logic [NVM_BYTES-1:0][7:0] mem_q;
  logic [NUM_SETTINGS-1:0][7:0] image_q;
  logic [3:0] idx_q;
  logic [15:0] timer_q;
  logic load_q;
  logic done_q;
  logic fault_q;

  wire prog_done = (timer_q == 16'(PROG_CYCLES - 1));
  wire last_idx = (idx_q == 4'(NVM_BYTES - 1));
  wire check_ok = (checksum(image_q) == mem_q[NVM_BYTES-1]);
  wire [7:0] wr_byte = last_idx ? checksum(image_q) : image_q[idx_q];

  // The whole block moves as one image; the check byte fills the spare byte.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_NONE;
      mem_q <= {FACTORY_CHECK, FACTORY_IMAGE};
      image_q <= FACTORY_IMAGE;
      idx_q <= 4'h0;
      timer_q <= 16'h0000;
      load_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (i_clk_en) begin
      load_q <= 1'b0;
      done_q <= 1'b0;
      idx_q <= 4'h0;
      timer_q <= 16'h0000;
      unique case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            cmd_q <= i_cmd;
            image_q <= i_image;
            unique case (i_cmd)
              CMD_SAVE: state_q <= ST_WRITE;
              CMD_RESTORE: state_q <= ST_READ;
              CMD_FACTORY: state_q <= ST_FACTORY;
              CMD_NONE: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_WRITE: begin
          idx_q <= idx_q;
          timer_q <= timer_q + 16'h0001;
          if (prog_done) begin
            mem_q[idx_q] <= wr_byte;
            timer_q <= 16'h0000;
            idx_q <= idx_q + 4'h1;
            if (last_idx) begin
              idx_q <= 4'h0;
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: begin
          image_q[idx_q] <= mem_q[idx_q];
          idx_q <= idx_q + 4'h1;
          if (idx_q == 4'(NUM_SETTINGS - 1)) begin
            idx_q <= 4'h0;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          fault_q <= !check_ok;
          load_q <= check_ok && (cmd_q == CMD_RESTORE);
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_FACTORY: begin
          image_q <= FACTORY_IMAGE;
          fault_q <= 1'b0;
          load_q <= 1'b1;
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state_q != ST_IDLE);
  assign o_done = done_q;
  assign o_load = load_q;
  assign o_load_image = image_q;
  assign o_integrity_fault = fault_q;

endmodule

// ===== logic/pmu_settings_register_bank.sv
// What this block does
// - Regulator one level_code gives 0.9 V plus 25 mV steps, ceiling 1.6 V.
// - Regulator two level_code gives 1.5 V plus 37.5 mV steps, ceiling 2.1 V.
// - Regulators three to five give 0.7 V plus 25 mV, ceiling 1.3 V.
// - Select bit low uses strap-pin voltage, high uses the level_code.
// - Overcurrent protection is on unless the overcurrent_disable bit is set.
// - Pulse_freq_disable set forces pulse-width operation at light load.
// - Power_up_order sets start position; five through seven start last.
// - Driver_slew codes select 500, 1000, 1500 or 2000 V/us.
// - Low_side_disable set turns off the low-side switch.
// - A set undervoltage mask bit suppresses that undervoltage fault.
// - Step_delay codes select none, 0.5, 1.0 or 2.0 ms between steps.
// - Main_delay_placement puts the main delay nowhere, before reset, before sequence, both.
// - Main_delay is 10 ms plus 2 ms per code, or fixed 8 ms.
// - Monitor_deglitch filters the regulator undervoltage monitors for 0, 1, 2 or 5 us; external and internal supply monitors are not filtered.
// - Deep_sleep bit set enters deep sleep, cleared leaves it.
// - Pull-down always when pulldown_always set, else except in deep sleep.
// - A set regulator_off bit turns its regulator off.
// - Store_busy stays high during store operations; writes are ignored meanwhile.
// - Integrity_fault shows whether the stored settings passed their check.
// - Store_command codes: none, save, restore saved, load factory values.
// - All fifteen setting registers transfer together, never in part.
// - Status shows live fault flags for temperature and each regulator.
module pmu_settings_register_bank #(
  parameter int STEP_UNIT_CYCLES = pmu_settings_pkg::STEP_UNIT_US * pmu_settings_pkg::CLK_MHZ,
  parameter int MS_CYCLES = 1000 * pmu_settings_pkg::CLK_MHZ,
  parameter int PROG_CYCLES = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Strap pins and monitors
  input wire logic [1:0] i_strap_pins,
  input wire logic [6:0] i_fault_raw,
  input wire logic [4:0] i_buck_uv,
  input wire logic i_ext_uv,
  input wire logic i_int_uv,
  // Regulator controls
  output pmu_settings_pkg::buck_ctrl_t [4:0] o_buck,
  output logic o_uv_fault,
  output logic o_deep_sleep,
  output logic o_ldo_pulldown,
  output logic o_ldo_off,
  // Sequencer settings
  output logic [pmu_settings_pkg::DLY_W-1:0] o_step_delay_cycles,
  output logic [pmu_settings_pkg::DLY_W-1:0] o_main_delay_cycles,
  output logic o_delay_before_por,
  output logic o_delay_before_seq
);
  import pmu_settings_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [VOLT_W-1:0] code_to_volt(input logic [1:0] cls, input logic [4:0] code);
    logic [4:0] c;
    c = (code >= VOLT_CEIL[cls]) ? VOLT_CEIL[cls] : code;
    return VOLT_BASE[cls] + VOLT_W'(VOLT_STEP[cls] * VOLT_W'(c));
  endfunction

  function automatic logic [1:0] volt_class(input int idx);
    return (idx > 1) ? 2'h2 : 2'(idx);
  endfunction

  // ----------------------------------------------------------------
  // Store engine
  // ----------------------------------------------------------------
  logic [NUM_SETTINGS-1:0][7:0] regs_q;
  store_cmd_t cmd_q;
  logic eng_busy;
  logic eng_done;
  logic eng_load;
  logic eng_fault;
  logic [NUM_SETTINGS-1:0][7:0] eng_image;

  wire wr_setting = i_reg_wr && (i_reg_addr < 8'(NUM_SETTINGS));
  wire wr_setting_control = i_reg_wr && (i_reg_addr == ADDR_SETTING_CONTROL);
  wire [1:0] wr_cmd = i_reg_wdata[1:0];
  wire eng_start = wr_setting_control && !eng_busy && (wr_cmd != 2'h0);

  nvm_store_engine #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_store (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .i_start(eng_start),
    .i_cmd(store_cmd_t'(wr_cmd)),
    .i_image(regs_q),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_load(eng_load),
    .o_load_image(eng_image),
    .o_integrity_fault(eng_fault)
  );

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regs_q <= FACTORY_IMAGE;
    end else if (i_clk_en) begin
      if (eng_load) begin
        regs_q <= eng_image;
      end else if (wr_setting && !eng_busy) begin
        regs_q[i_reg_addr[3:0]] <= i_reg_wdata;
      end
    end
  end

  // A new command is only taken when idle; the field clears itself when done.
  // A command taken in the cycle the last one ends wins, or the new run would read as idle.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_NONE;
    end else if (i_clk_en && eng_start) begin
      cmd_q <= store_cmd_t'(wr_cmd);
    end else if (i_clk_en && eng_done) begin
      cmd_q <= CMD_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps are caught on the first enabled edge after reset release only.
  logic [1:0] strap_q;
  logic strap_taken_q;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= 2'h0;
      strap_taken_q <= 1'b0;
    end else if (i_clk_en && !strap_taken_q) begin
      strap_q <= i_strap_pins;
      strap_taken_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Regulator decode
  // ----------------------------------------------------------------
  wire [7:0] seq_reg = regs_q[ADDR_SEQ[3:0]];
  wire [7:0] sup_reg = regs_q[ADDR_SUPPLY[3:0]];
  wire [7:0] ctrl_reg = regs_q[ADDR_REGULATOR_CONTROL[3:0]];
  wire [1:0] monitor_deglitch_code = sup_reg[SUP_MONITOR_DEGLITCH_LSB +: 2];
  wire [7:0] monitor_deglitch_limit = 8'(MONITOR_DEGLITCH_US[monitor_deglitch_code] * CLK_MHZ);
  buck_ctrl_t [4:0] buck_d;
  buck_ctrl_t [4:0] buck_q;
  logic [4:0] uv_filt;

  for (genvar g = 0; g < NUM_BUCKS; g++) begin : g_buck
    wire [7:0] vl = regs_q[VL_ADDR[g]];
    wire [7:0] cfg = regs_q[CFG_ADDR[g]];
    logic [7:0] monitor_deglitch_cnt_q;

    wire [VOLT_W-1:0] reg_volt = code_to_volt(volt_class(g), vl[4:0]);
    assign buck_d[g].volt_half_mv = vl[VL_SEL_BIT] ? reg_volt : STRAP_VOLT[volt_class(g)][strap_q];
    assign buck_d[g].oc_enable = !vl[VL_OC_BIT];
    assign buck_d[g].force_pwm = cfg[CFG_PFM_BIT];
    assign buck_d[g].order = cfg[CFG_ORDER_LSB +: 3];
    assign buck_d[g].slew_v_per_us = SLEW_STEP * 11'({1'b0, cfg[CFG_SLEW_LSB +: 2]} + 3'h1);
    assign buck_d[g].low_side_off = cfg[CFG_LS_BIT];
    assign buck_d[g].uv_fault_en = !cfg[CFG_UVM_BIT];
    assign buck_d[g].off = ctrl_reg[OFF_BIT[g]];

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        monitor_deglitch_cnt_q <= 8'h00;
      end else if (i_clk_en) begin
        if (!i_buck_uv[g]) begin
          monitor_deglitch_cnt_q <= 8'h00;
        end else if (monitor_deglitch_cnt_q < monitor_deglitch_limit) begin
          monitor_deglitch_cnt_q <= monitor_deglitch_cnt_q + 8'h01;
        end
      end
    end
    assign uv_filt[g] = i_buck_uv[g] && (monitor_deglitch_cnt_q >= monitor_deglitch_limit);
  end

  // ----------------------------------------------------------------
  // Sequencer and supply decode
  // ----------------------------------------------------------------
  // step delay
  wire [1:0] step_code = seq_reg[SEQ_STEP_LSB +: 2];
  wire [2:0] step_units = (step_code == 2'h3) ? 3'h4 : {1'b0, step_code};
  wire [DLY_W-1:0] step_d = DLY_W'(STEP_UNIT_CYCLES * int'(step_units));
  wire [DLY_W-1:0] main_d = seq_reg[SEQ_FIX_BIT] ? DLY_W'(MAIN_FIXED_MS * MS_CYCLES) :
                            DLY_W'((MAIN_BASE_MS + MAIN_STEP_MS * int'(seq_reg[2:0])) * MS_CYCLES);
  wire [1:0] place = seq_reg[SEQ_PLACE_LSB +: 2];
  wire [NUM_BUCKS-1:0] uv_en = {buck_d[4].uv_fault_en, buck_d[3].uv_fault_en, buck_d[2].uv_fault_en,
                                buck_d[1].uv_fault_en, buck_d[0].uv_fault_en};
  wire uv_d = |(uv_filt & uv_en) || (i_ext_uv && !sup_reg[SUP_EXTERNAL_SUPPLY_MASK_BIT]) ||
              (i_int_uv && !sup_reg[SUP_INTERNAL_SUPPLY_MASK_BIT]);
  wire deep_sleep = ctrl_reg[CTRL_DSM_BIT];
  wire pulldown_d = ctrl_reg[CTRL_PD_BIT] || !deep_sleep;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buck_q <= '0;
      o_uv_fault <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_ldo_pulldown <= 1'b0;
      o_ldo_off <= 1'b0;
      o_step_delay_cycles <= '0;
      o_main_delay_cycles <= '0;
      o_delay_before_por <= 1'b0;
      o_delay_before_seq <= 1'b0;
    end else if (i_clk_en) begin
      buck_q <= buck_d;
      o_uv_fault <= uv_d;
      o_deep_sleep <= deep_sleep;
      o_ldo_pulldown <= pulldown_d;
      o_ldo_off <= ctrl_reg[CTRL_LDO_BIT];
      o_step_delay_cycles <= step_d;
      o_main_delay_cycles <= main_d;
      o_delay_before_por <= place[0];
      o_delay_before_seq <= place[1];
    end
  end
  assign o_buck = buck_q;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // busy flag shown
  wire [7:0] setting_control_rd = {4'h0, eng_busy, eng_fault, cmd_q};
  wire [7:0] status_rd = {1'b0, i_fault_raw};
  wire [7:0] rd_mux = (i_reg_addr < 8'(NUM_SETTINGS)) ? regs_q[i_reg_addr[3:0]] :
                      (i_reg_addr == ADDR_SETTING_CONTROL) ? setting_control_rd :
                      (i_reg_addr == ADDR_STATUS) ? status_rd : 8'h00;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  busy_write_lock_a: assert property (
    i_clk_en && eng_busy && wr_setting && !eng_load |=> regs_q == $past(regs_q))
    else $error("Setting register changed while store busy.");

  buck_one_ceiling_a: assert property (
    i_clk_en && regs_q[VL_ADDR[0]][VL_SEL_BIT] && regs_q[VL_ADDR[0]][4:0] >= 5'h1C
    |=> o_buck[0].volt_half_mv == 13'h0C80)
    else $error("Regulator one not clamped at ceiling.");

  buck_two_ceiling_a: assert property (
    i_clk_en && regs_q[VL_ADDR[1]][VL_SEL_BIT] && regs_q[VL_ADDR[1]][4:0] >= 5'h10
    |=> o_buck[1].volt_half_mv == 13'h1068)
    else $error("Regulator two not clamped at ceiling.");

  buck_three_scale_a: assert property (
    i_clk_en && regs_q[VL_ADDR[2]][VL_SEL_BIT] && regs_q[VL_ADDR[2]][4:0] < 5'h18
    |=> o_buck[2].volt_half_mv == 13'h0578 + 13'($past(regs_q[VL_ADDR[2]][4:0])) * 13'h0032)
    else $error("Regulator three scale wrong.");

  strap_select_a: assert property (
    i_clk_en && strap_taken_q && !regs_q[VL_ADDR[4]][VL_SEL_BIT]
    |=> o_buck[4].volt_half_mv == STRAP_VOLT[2][strap_q])
    else $error("Strap voltage not applied.");

  pulldown_mode_a: assert property (
    i_clk_en && deep_sleep && !ctrl_reg[CTRL_PD_BIT] |=> !o_ldo_pulldown)
    else $error("Pull-down active in deep sleep.");

  cmd_clear_done_a: assert property (
    i_clk_en && eng_done && !eng_start |=> cmd_q == CMD_NONE)
    else $error("Store command not cleared after completion.");

  busy_cmd_ignored_a: assert property (
    i_clk_en && eng_busy && wr_setting_control && !eng_done |=> $stable(cmd_q) && (eng_busy || eng_done))
    else $error("Command taken while busy.");

  main_fixed_a: assert property (
    i_clk_en && seq_reg[SEQ_FIX_BIT] |=> o_main_delay_cycles == DLY_W'(MAIN_FIXED_MS * MS_CYCLES))
    else $error("Fixed main delay wrong.");

  status_live_a: assert property (
    i_clk_en && i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata == {1'b0, $past(i_fault_raw)})
    else $error("Status read does not show fault inputs.");

  save_seen_c: cover property (i_clk_en && eng_start && wr_cmd == 2'h1);
  restore_seen_c: cover property (i_clk_en && eng_load && cmd_q == CMD_RESTORE);
  factory_seen_c: cover property (i_clk_en && eng_load && cmd_q == CMD_FACTORY);
  integrity_fail_c: cover property (i_clk_en && eng_done ##1 eng_fault);

endmodule

// ===== test/host_model.sv
module host_model (
  // Clock and answer
  input wire logic i_clk_sys,
  input wire logic i_reg_rvalid,
  input wire logic [7:0] i_reg_rdata,
  // Request
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_addr, o_wr, o_wdata, o_rd} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    ok = 1'b0;
    d = 8'hXX;
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge i_clk_sys);
      ok = (i_reg_rvalid === 1'b1);
      d = i_reg_rdata;
    end
    if (!ok) d = 8'hXX;
  endtask
endmodule

// ===== test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pmu_settings_pkg::*;
  logic i_clk_sys = 0;
  logic i_reset_n = 0;
  logic [7:0] addr, wdata, rdata, d, rc;
  logic wr, rd, rvalid, uv, deep_sleep, pd, ldo_off, dbp, dbs;
  logic [1:0] strap = 0;
  logic [6:0] fault = 0;
  logic ext_uv = 0, int_uv = 0, clk_en = 1;
  logic [4:0] buck_uv = 0;
  buck_ctrl_t [4:0] buck;
  logic [DLY_W-1:0] step_c, main_c;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  pmu_settings_register_bank #(.STEP_UNIT_CYCLES(5), .MS_CYCLES(10), .PROG_CYCLES(2)) pmu_settings_register_bank_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(clk_en), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_strap_pins(strap),
    .i_fault_raw(fault), .i_buck_uv(buck_uv), .i_ext_uv(ext_uv), .i_int_uv(int_uv), .o_buck(buck), .o_uv_fault(uv),
    .o_deep_sleep(deep_sleep), .o_ldo_pulldown(pd), .o_ldo_off(ldo_off), .o_step_delay_cycles(step_c),
    .o_main_delay_cycles(main_c), .o_delay_before_por(dbp), .o_delay_before_seq(dbs));
  host_model host_model_i (.i_clk_sys(i_clk_sys), .i_reg_rvalid(rvalid), .i_reg_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] volt(input int r, input logic [4:0] c);
    int m;
    m = (r == 0) ? 28 : (r == 1) ? 16 : 24;
    return ((r == 0) ? 1800 : (r == 1) ? 3000 : 1400) + ((r == 1) ? 75 : 50) * ((c > m) ? m : c);
  endfunction
  task automatic idle;
    logic [7:0] s;
    s = 8'h08;
    for (int i = 0; i < 100 && s[3] !== 1'b0; i++) host_model_i.rd(ADDR_SETTING_CONTROL, s);
    chk("idle", s[3], 0);
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    void'($urandom(26));
    strap <= 2'($urandom);
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    host_model_i.rd(ADDR_REGULATOR_CONTROL, d);
    chk("regulator_control reset", d, 8'h40);
    chk("main delay", main_c, 80);
    chk("step delay", step_c, 5);
    // With the clock enable low a write must not land.
    clk_en <= 1'b0;
    host_model_i.wr(8'h06, 8'h77);
    clk_en <= 1'b1;
    host_model_i.rd(8'h06, d);
    chk("frozen", d, 8'h00);
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 4; k++) begin
        d = 8'($urandom);
        d[7] = (k != 1);
        if (k == 0) d[4:0] = 5'h1F;
        host_model_i.wr(8'(VL_ADDR[i]), d);
        repeat (3) @(posedge i_clk_sys);
        chk("volt", buck[i].volt_half_mv, d[7] ? volt(i, d[4:0]) : STRAP_VOLT[(i < 2) ? i : 2][strap]);
        chk("oc", buck[i].oc_enable, !d[6]);
        d = 8'($urandom);
        host_model_i.wr(8'(CFG_ADDR[i]), d);
        repeat (3) @(posedge i_clk_sys);
        chk("cfg", {buck[i].force_pwm, buck[i].order, buck[i].slew_v_per_us, buck[i].low_side_off,
          buck[i].uv_fault_en}, {d[7], d[6:4], 11'((d[3:2] + 1) * 500), d[1], !d[0]});
      end
    end
    d = 8'($urandom);
    host_model_i.wr(ADDR_SEQ, d);
    repeat (3) @(posedge i_clk_sys);
    chk("step", step_c, (d[6:5] == 3) ? 20 : d[6:5] * 5);
    chk("main", main_c, d[7] ? 80 : (10 + 2 * d[2:0]) * 10);
    chk("place", {dbs, dbp}, d[4:3]);
    rc = 8'($urandom);
    host_model_i.wr(ADDR_REGULATOR_CONTROL, rc);
    repeat (3) @(posedge i_clk_sys);
    chk("dsm", deep_sleep, rc[7]);
    chk("pulldown", pd, rc[6] | !rc[7]);
    chk("off", {buck[4].off, buck[3].off, buck[1].off, buck[2].off, buck[0].off, ldo_off}, rc[5:0]);
    for (int m = 0; m < 8; m++) begin
      d = 8'($urandom) & 8'h18;
      ext_uv <= 1'($urandom);
      int_uv <= 1'($urandom);
      host_model_i.wr(ADDR_SUPPLY, d);
      repeat (3) @(posedge i_clk_sys);
      chk("uv", uv, (ext_uv & !d[4]) | (int_uv & !d[3]));
    end
    // Regulator one undervoltage through the longest deglitch time, then masked.
    ext_uv <= 1'b0;
    int_uv <= 1'b0;
    host_model_i.wr(8'(CFG_ADDR[0]), 8'h00);
    host_model_i.wr(ADDR_SUPPLY, 8'h06);
    buck_uv <= 5'h01;
    repeat (50) @(posedge i_clk_sys);
    chk("deglitch early", uv, 0);
    repeat (60) @(posedge i_clk_sys);
    chk("deglitch late", uv, 1);
    host_model_i.wr(8'(CFG_ADDR[0]), 8'h01);
    repeat (3) @(posedge i_clk_sys);
    chk("buck mask", uv, 0);
    buck_uv <= 5'h00;
    fault <= 7'($urandom);
    host_model_i.rd(ADDR_STATUS, d);
    chk("status", d, {1'b0, fault});
    host_model_i.rd(8'h20, d);
    chk("unmapped", d, 0);
    host_model_i.wr(8'h06, 8'h5A);
    host_model_i.wr(ADDR_SETTING_CONTROL, 8'h01);
    host_model_i.rd(ADDR_SETTING_CONTROL, d);
    chk("busy", d[3], 1);
    // Both writes land mid-save and must leave no trace.
    host_model_i.wr(8'h06, 8'hC3);
    host_model_i.wr(ADDR_SETTING_CONTROL, 8'h03);
    idle();
    host_model_i.rd(8'h06, d);
    chk("locked", d, 8'h5A);
    host_model_i.rd(ADDR_SETTING_CONTROL, d);
    chk("setting_control", d[3:0], 0);
    host_model_i.wr(8'h06, 8'h11);
    host_model_i.wr(ADDR_REGULATOR_CONTROL, 8'h00);
    host_model_i.wr(ADDR_SETTING_CONTROL, 8'h02);
    idle();
    host_model_i.rd(8'h06, d);
    chk("restore", d, 8'h5A);
    host_model_i.rd(ADDR_REGULATOR_CONTROL, d);
    chk("restore end", d, rc);
    host_model_i.wr(ADDR_SETTING_CONTROL, 8'h03);
    idle();
    host_model_i.rd(ADDR_REGULATOR_CONTROL, d);
    chk("factory", d, 8'h40);
    final_report();
  end
endmodule
